// File: hw/rclmc_pkg.sv
// shared constants and types for the rate converter control block
package rclmc_pkg;
   localparam int CLK_HZ      = 20_000_000;
   localparam int LOCK_MS     = 100;
   localparam int LOCK_CYC    = CLK_HZ / 1000 * LOCK_MS;
   localparam int SENSE_MS    = 4;
   localparam int SENSE_CYC   = CLK_HZ / 1000 * SENSE_MS;
   localparam int RAMP_INTERP = 27488;
   localparam int RAMP_DECIM  = 54976;
   localparam int XTAL_IDLE   = 1024;
   localparam logic [15:0] RAMP_FULL   = 16'hd6c0;
   localparam logic [15:0] STEP_INTERP = 16'h0002;
   localparam logic [15:0] STEP_DECIM  = 16'h0001;
   localparam logic [7:0]  IDX_CLK     = 8'h08;
   localparam logic [7:0]  IDX_STAT    = 8'h15;
   localparam logic [11:0] ADDR_CLK    = {2'h0, IDX_CLK, 2'h0};
   localparam logic [11:0] ADDR_STAT   = {2'h0, IDX_STAT, 2'h0};
   localparam int CLK_SEL_LSB = 0;
   localparam int CLK_HALVE   = 2;
   localparam int CLK_SD2_SRC = 3;
   localparam logic [31:0] CLK_RST     = 32'h0000_0000;
   localparam logic [7:0]  RATE_LO     = 8'h31;
   localparam logic [7:0]  RATE_MID_LO = 8'h3c;
   localparam logic [7:0]  RATE_MID_HI = 8'h62;
   localparam logic [7:0]  RATE_HI     = 8'h78;
   localparam logic [9:0]  PLL_X512    = 10'h200;
   localparam logic [9:0]  PLL_X256    = 10'h100;
   localparam logic [9:0]  PLL_X128    = 10'h080;
   typedef enum logic [1:0] {
      CSRC_XTAL = 2'h0,
      CSRC_PLL  = 2'h1,
      CSRC_RING = 2'h2
   } rclmc_csrc_e;
   typedef enum logic [1:0] {
      ST_SENSE  = 2'h0,
      ST_CALC   = 2'h1,
      ST_SETTLE = 2'h3,
      ST_RUN    = 2'h2
   } rclmc_state_e;
   typedef struct packed {
      logic hw_mode;
      logic deemph_auto_en;
      logic sd1_mclk_recovered;
      logic src_pll_sel;
      logic tx_user_data;
      logic err_receiver;
      logic vaudio_audio;
   } rclmc_straps_s;
endpackage

// File: hw/rclmc_top.sv
// lock, mute and master clock control around the rate converter
`timescale 1ns/1ps
`default_nettype none
// Function
// R1 - measure input/output rate ratio before use, about 100 ms at 48 kHz
// R2 - unlock flag goes high on reset and on any input or output rate change; the hardware-mode pin is driven low during reset
// R3 - unlock stays high until locked and settled; low means valid audio
// R4 - unlock readable at register 15h in software mode, pin in hardware mode
// R5 - converter-fed serial output gives zero samples right after reset
// R6 - soft unmute over 27488 input or 54976 output sample periods
// R7 - hard mute at once when invalid; soft unmute only after all clears
// R8 - converter clock from crystal, receiver PLL or ring oscillator
// R9 - crystal above 33 MHz needs the halving bit in register 08h
// R10 - PLL clock follows receiver data or input bit clock, ratio fixed
// R11 - PLL ratio 512 up to 49 kHz, 256 for 60-98 kHz, 128 from 120 kHz
// R12 - hardware mode uses ring oscillator, PLL if its strap pulled up
// R13 - software mode picks converter clock by two-bit field at 08h
// R14 - static crystal input falls back to the ring oscillator
// R15 - hardware mode when channel-status strap pulled up at reset release
// R16 - input selects live; straps sampled only once at startup
// R17 - receiver input select pin picks input 0 low, input 1 high
// R18 - pass-through select pin picks input 0 low, input 1 high
// R19 - first serial output strap: pull-up disables de-emphasis detect
// R20 - recovered clock strap: pull-up selects recovered clock for port 1
// R21 - transmit/user strap: pull-up selects user data output
// R22 - error strap: pull-up selects plain receiver error indication
// R23 - validity/audio strap: pull-up selects non-audio indicator
// R24 - hardware mode senses mode pins 4 ms, unlocked and both outputs muted
module rclmc_top #(
   parameter int LOCK_CYC    = rclmc_pkg::LOCK_CYC,
   parameter int SENSE_CYC   = rclmc_pkg::SENSE_CYC,
   parameter int RAMP_INTERP = rclmc_pkg::RAMP_INTERP,
   parameter int RAMP_DECIM  = rclmc_pkg::RAMP_DECIM
) (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        fsi_change,
   input  wire logic        fso_change,
   input  wire logic        fsi_tick,
   input  wire logic        fso_tick,
   input  wire logic        core_settled,
   input  wire logic [7:0]  input_rate_khz,
   input  wire logic        crystal_in,
   input  wire logic        strap_c,
   input  wire logic        strap_first_sdout,
   input  wire logic        strap_recovered_master_clock,
   input  wire logic        strap_mclk_out,
   input  wire logic        strap_txu,
   input  wire logic        strap_err,
   input  wire logic        strap_vaudio,
   input  wire logic        rx_sel_pin,
   input  wire logic        tx_sel_pin,
   output logic             rate_converter_unlocked,
   output logic      [15:0] sd1_gain,
   output logic      [15:0] sd2_gain,
   output logic      [1:0]  converter_clock_select,
   output logic             converter_clock_halve,
   output logic      [9:0]  pll_ratio,
   output logic             hw_mode,
   output logic             deemph_auto_en,
   output logic             sd1_mclk_recovered,
   output logic             tx_user_data_sel,
   output logic             err_receiver_sel,
   output logic             vaudio_audio_sel,
   output logic             rx_input_sel,
   output logic             tx_input_sel
);
   localparam logic [31:0] LOCK_LAST  = 32'(LOCK_CYC - 1);
   localparam logic [31:0] SENSE_LAST = 32'(SENSE_CYC - 1);
   rclmc_pkg::rclmc_state_e  st_reg;
   rclmc_pkg::rclmc_state_e  st_next;
   rclmc_pkg::rclmc_straps_s straps_reg;
   logic        strap_done_reg;
   logic [31:0] timer_reg;
   logic [15:0] fsi_cnt_reg;
   logic [15:0] fso_cnt_reg;
   logic        interp_reg;
   logic        unlocked_reg;
   logic [15:0] ramp_reg;
   logic [31:0] clk_ctrl_reg;
   logic        xtal_prev_reg;
   logic [10:0] idle_cnt_reg;
   logic        xtal_static;
   logic        rate_chg;
   logic        ramp_tick;
   logic [15:0] ramp_step;
   logic [1:0]  sel_raw;
   logic        apb_wr;
   logic        apb_rd;
   assign rate_chg  = fsi_change | fso_change;
   assign ramp_tick = interp_reg ? fsi_tick : fso_tick;
   assign ramp_step = interp_reg ? rclmc_pkg::STEP_INTERP
                                 : rclmc_pkg::STEP_DECIM;
   assign apb_wr    = psel & penable & pready & pwrite;
   assign apb_rd    = psel & ~penable & ~pwrite;
   // straps caught once, on the first cycle after reset release
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         strap_done_reg <= 1'b0;
         straps_reg     <= '0;
      end else if (!strap_done_reg) begin
         strap_done_reg            <= 1'b1; // R16
         straps_reg.hw_mode        <= strap_c; // R15
         straps_reg.deemph_auto_en <= ~strap_first_sdout; // R19
         straps_reg.sd1_mclk_recovered <= strap_recovered_master_clock; // R20
         straps_reg.src_pll_sel    <= strap_mclk_out; // R12
         straps_reg.tx_user_data   <= strap_txu; // R21
         straps_reg.err_receiver   <= strap_err; // R22
         straps_reg.vaudio_audio   <= strap_vaudio; // R23
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         hw_mode            <= 1'b0;
         deemph_auto_en     <= 1'b0;
         sd1_mclk_recovered <= 1'b0;
         tx_user_data_sel   <= 1'b0;
         err_receiver_sel   <= 1'b0;
         vaudio_audio_sel   <= 1'b0;
         rx_input_sel       <= 1'b0;
         tx_input_sel       <= 1'b0;
      end else begin
         hw_mode            <= straps_reg.hw_mode;
         deemph_auto_en     <= straps_reg.deemph_auto_en;
         sd1_mclk_recovered <= straps_reg.sd1_mclk_recovered;
         tx_user_data_sel   <= straps_reg.tx_user_data;
         err_receiver_sel   <= straps_reg.err_receiver;
         vaudio_audio_sel   <= straps_reg.vaudio_audio;
         // live pins, followed at any time in hardware mode
         rx_input_sel <= straps_reg.hw_mode & rx_sel_pin; // R17 R16
         tx_input_sel <= straps_reg.hw_mode & tx_sel_pin; // R18 R16
      end
   end
   // lock sequence
   always_comb begin
      st_next = st_reg;
      case (st_reg)
         rclmc_pkg::ST_SENSE: begin
            // software mode needs no pin sensing
            if (strap_done_reg &&
                (!straps_reg.hw_mode || timer_reg == SENSE_LAST)) begin
               st_next = rclmc_pkg::ST_CALC; // R24
            end
         end
         rclmc_pkg::ST_CALC: begin
            if (timer_reg == LOCK_LAST) begin
               st_next = rclmc_pkg::ST_SETTLE; // R1
            end
         end
         rclmc_pkg::ST_SETTLE: begin
            if (core_settled) begin
               st_next = rclmc_pkg::ST_RUN; // R3
            end
         end
         rclmc_pkg::ST_RUN: begin
            st_next = rclmc_pkg::ST_RUN;
         end
         default: begin
            st_next = rclmc_pkg::ST_SENSE;
         end
      endcase
      // a rate change restarts the measurement, except while sensing
      if (rate_chg && st_reg != rclmc_pkg::ST_SENSE) begin
         st_next = rclmc_pkg::ST_CALC; // R2
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_reg <= rclmc_pkg::ST_SENSE;
      end else begin
         st_reg <= st_next;
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst || st_next != st_reg ||
          (rate_chg && st_reg != rclmc_pkg::ST_SENSE)) begin
         timer_reg <= 32'h0; // R2
      end else if (st_reg == rclmc_pkg::ST_SENSE && strap_done_reg) begin
         timer_reg <= timer_reg + 32'h1;
      end else if (st_reg == rclmc_pkg::ST_CALC) begin
         timer_reg <= timer_reg + 32'h1;
      end
   end
   // ratio: sample ticks of both sides over the same window
   always_ff @(posedge clk) begin
      if (sys_rst || st_reg != rclmc_pkg::ST_CALC || rate_chg) begin
         fsi_cnt_reg <= 16'h0;
         fso_cnt_reg <= 16'h0;
      end else begin
         if (fsi_tick && fsi_cnt_reg != 16'hffff) begin
            fsi_cnt_reg <= fsi_cnt_reg + 16'h1; // R1
         end
         if (fso_tick && fso_cnt_reg != 16'hffff) begin
            fso_cnt_reg <= fso_cnt_reg + 16'h1; // R1
         end
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         interp_reg <= 1'b0;
      end else if (st_reg == rclmc_pkg::ST_CALC &&
                   st_next == rclmc_pkg::ST_SETTLE) begin
         interp_reg <= fso_cnt_reg > fsi_cnt_reg; // R1
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         unlocked_reg <= 1'b1; // R2
      end else begin
         unlocked_reg <= st_next != rclmc_pkg::ST_RUN; // R2 R3 R24
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rate_converter_unlocked <= 1'b0;
      end else begin
         // pin only carries the flag in hardware mode
         rate_converter_unlocked <= straps_reg.hw_mode &
                                    (st_next != rclmc_pkg::ST_RUN); // R4
      end
   end
   // soft unmute ramp; one scale covers both lengths
   always_ff @(posedge clk) begin
      if (sys_rst || st_next != rclmc_pkg::ST_RUN) begin
         ramp_reg <= 16'h0; // R5 R7
      end else if (ramp_tick) begin
         if (ramp_reg > rclmc_pkg::RAMP_FULL - ramp_step) begin
            ramp_reg <= rclmc_pkg::RAMP_FULL;
         end else begin
            ramp_reg <= ramp_reg + ramp_step; // R6
         end
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sd1_gain <= 16'h0;
         sd2_gain <= 16'h0;
      end else if (st_next == rclmc_pkg::ST_SENSE) begin
         sd1_gain <= 16'h0; // R24
         sd2_gain <= 16'h0; // R24
      end else begin
         // port 1 is always converter-fed in hardware mode
         sd1_gain <= ramp_reg; // R5
         if (!straps_reg.hw_mode &&
             clk_ctrl_reg[rclmc_pkg::CLK_SD2_SRC]) begin
            sd2_gain <= ramp_reg; // R5
         end else begin
            sd2_gain <= rclmc_pkg::RAMP_FULL;
         end
      end
   end
   // crystal activity; a rail-tied input never toggles
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         xtal_prev_reg <= 1'b0;
         idle_cnt_reg  <= 11'h0;
      end else begin
         xtal_prev_reg <= crystal_in;
         if (crystal_in != xtal_prev_reg) begin
            idle_cnt_reg <= 11'h0;
         end else if (!xtal_static) begin
            idle_cnt_reg <= idle_cnt_reg + 11'h1;
         end
      end
   end
   assign xtal_static = idle_cnt_reg == 11'(rclmc_pkg::XTAL_IDLE);
   assign sel_raw = clk_ctrl_reg[rclmc_pkg::CLK_SEL_LSB +: 2];
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         converter_clock_select <= rclmc_pkg::CSRC_RING;
         converter_clock_halve  <= 1'b0;
      end else if (straps_reg.hw_mode) begin
         converter_clock_halve <= 1'b0;
         if (straps_reg.src_pll_sel) begin
            converter_clock_select <= rclmc_pkg::CSRC_PLL; // R12
         end else begin
            converter_clock_select <= rclmc_pkg::CSRC_RING; // R12
         end
      end else begin
         case (sel_raw)
            rclmc_pkg::CSRC_XTAL: begin
               if (xtal_static) begin
                  converter_clock_select <= rclmc_pkg::CSRC_RING; // R14
                  converter_clock_halve  <= 1'b0;
               end else begin
                  converter_clock_select <= rclmc_pkg::CSRC_XTAL; // R8 R13
                  // only the crystal path has the divider
                  converter_clock_halve <=
                     clk_ctrl_reg[rclmc_pkg::CLK_HALVE]; // R9
               end
            end
            rclmc_pkg::CSRC_PLL: begin
               converter_clock_select <= rclmc_pkg::CSRC_PLL; // R8 R13
               converter_clock_halve  <= 1'b0;
            end
            default: begin
               converter_clock_select <= rclmc_pkg::CSRC_RING; // R8 R13
               converter_clock_halve  <= 1'b0;
            end
         endcase
      end
   end
   // fixed by measured rate, no software path; gaps keep the last ratio
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pll_ratio <= rclmc_pkg::PLL_X512;
      end else if (input_rate_khz <= rclmc_pkg::RATE_LO) begin
         pll_ratio <= rclmc_pkg::PLL_X512; // R11 R10
      end else if (input_rate_khz >= rclmc_pkg::RATE_MID_LO &&
                   input_rate_khz <= rclmc_pkg::RATE_MID_HI) begin
         pll_ratio <= rclmc_pkg::PLL_X256; // R11 R10
      end else if (input_rate_khz >= rclmc_pkg::RATE_HI) begin
         pll_ratio <= rclmc_pkg::PLL_X128; // R11 R10
      end
   end
   // apb slave, one wait-free access phase
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & paddr != rclmc_pkg::ADDR_CLK &
                    paddr != rclmc_pkg::ADDR_STAT;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         clk_ctrl_reg <= rclmc_pkg::CLK_RST;
      end else if (apb_wr && paddr == rclmc_pkg::ADDR_CLK) begin
         clk_ctrl_reg <= {28'h0, pwdata[3:0]}; // R13 R9
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         prdata <= 32'h0;
      end else if (apb_rd && paddr == rclmc_pkg::ADDR_CLK) begin
         prdata <= clk_ctrl_reg;
      end else if (apb_rd && paddr == rclmc_pkg::ADDR_STAT) begin
         prdata <= {24'h0, converter_clock_halve, converter_clock_select,
                    interp_reg, st_reg, straps_reg.hw_mode,
                    unlocked_reg}; // R4
      end else if (apb_rd) begin
         prdata <= 32'h0;
      end
   end
   unlock_change_a: assert property (@(posedge clk) disable iff (sys_rst) // R2
      rate_chg && strap_done_reg && st_reg != rclmc_pkg::ST_SENSE
      |=> unlocked_reg && ramp_reg == 16'h0)
      else $error("rate change did not unlock");
   reset_mute_a: assert property (@(posedge clk) // R5
      $fell(sys_rst) |-> unlocked_reg && sd1_gain == 16'h0)
      else $error("not muted after reset");
   hard_mute_a: assert property (@(posedge clk) disable iff (sys_rst) // R7
      st_reg != rclmc_pkg::ST_RUN |=> sd1_gain == 16'h0)
      else $error("invalid output not hard muted");
   lock_time_a: assert property (@(posedge clk) disable iff (sys_rst) // R1
      st_reg == rclmc_pkg::ST_SETTLE && $past(st_reg) == rclmc_pkg::ST_CALC
      |-> $past(timer_reg) == LOCK_LAST)
      else $error("ratio window length wrong");
   lock_valid_a: assert property (@(posedge clk) disable iff (sys_rst) // R3
      $fell(unlocked_reg) |-> $past(core_settled))
      else $error("unlock cleared before settle");
   pin_mode_a: assert property (@(posedge clk) disable iff (sys_rst) // R4
      rate_converter_unlocked |-> straps_reg.hw_mode && unlocked_reg)
      else $error("unlock pin driven outside hardware mode");
   ramp_step_a: assert property (@(posedge clk) disable iff (sys_rst) // R6
      st_reg == rclmc_pkg::ST_RUN && st_next == rclmc_pkg::ST_RUN &&
      interp_reg && fsi_tick && ramp_reg < 16'hd6be
      |=> ramp_reg == $past(ramp_reg) + 16'h2)
      else $error("interpolation ramp step wrong");
   pll_ratio_a: assert property (@(posedge clk) disable iff (sys_rst) // R11
      input_rate_khz >= rclmc_pkg::RATE_HI |=> pll_ratio == 10'h080)
      else $error("high rate pll ratio wrong");
   xtal_fall_a: assert property (@(posedge clk) disable iff (sys_rst) // R14
      !straps_reg.hw_mode && sel_raw == rclmc_pkg::CSRC_XTAL && xtal_static
      |=> converter_clock_select == rclmc_pkg::CSRC_RING)
      else $error("static crystal kept selected");
   strap_hold_a: assert property (@(posedge clk) disable iff (sys_rst) // R16
      strap_done_reg && $past(strap_done_reg) |-> $stable(straps_reg))
      else $error("straps changed after startup");
   sense_mute_a: assert property (@(posedge clk) disable iff (sys_rst) // R24
      st_reg == rclmc_pkg::ST_SENSE |-> unlocked_reg &&
      sd1_gain == 16'h0 && sd2_gain == 16'h0)
      else $error("outputs live during sensing");
endmodule
`default_nettype wire

// File: test/rclmc_dac_model.sv
// downstream reader model: sample ticks and mute watch
`timescale 1ns/1ps
`default_nettype none
module rclmc_dac_model (
   input  wire logic        clk,
   input  wire logic        interp,
   input  wire logic        unlocked,
   input  wire logic [15:0] gain,
   output logic             fsi_tick,
   output logic             fso_tick,
   output logic             bad
);
   logic       ph  = 1'b0;
   logic [1:0] cnt = 2'h0;
   // interpolating: output rate twice the input rate
   assign fsi_tick = interp ? ph : 1'b1;
   assign fso_tick = interp ? 1'b1 : ph;
   assign bad      = (cnt == 2'h3);
   always_ff @(posedge clk) begin
      ph <= ~ph;
   end
   // audio only trusted while unlock low; two edges of lag allowed
   always_ff @(posedge clk) begin
      if (unlocked && gain != 16'h0000) begin
         cnt <= (cnt == 2'h3) ? cnt : cnt + 2'h1;
      end else begin
         cnt <= 2'h0;
      end
   end
endmodule
`default_nettype wire

// File: test/rclmc_top_tb_top.sv
// self-checking bench for the rate converter control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
   n_errors++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module rclmc_top_tb_top;
   localparam int LK = 50;
   localparam int SN = 20;
   logic clk, sys_rst, psel, penable, pwrite, ip, bad;
   logic fsi_change, fso_change, fsi_tick, fso_tick, core_settled;
   logic crystal_in, xrun, rx_sel_pin, tx_sel_pin, pready, pslverr, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [7:0]  rate;
   logic [6:0]  st, st0;
   logic [15:0] sd1_gain, sd2_gain;
   logic [1:0]  sel, csel;
   logic [9:0]  pll_ratio, pe;
   logic unl, halve, hw, dae, smr, txu, erx, vau, rxs, txs;
   int seed, n_errors, compares, n, i;
   rclmc_top #(.LOCK_CYC(LK), .SENSE_CYC(SN)) uut (
      .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .fsi_change(fsi_change),
      .fso_change(fso_change), .fsi_tick(fsi_tick), .fso_tick(fso_tick),
      .core_settled(core_settled), .input_rate_khz(rate),
      .crystal_in(crystal_in), .strap_c(st[6]), .strap_first_sdout(st[5]),
      .strap_recovered_master_clock(st[4]), .strap_mclk_out(st[3]), .strap_txu(st[2]),
      .strap_err(st[1]), .strap_vaudio(st[0]), .rx_sel_pin(rx_sel_pin),
      .tx_sel_pin(tx_sel_pin), .rate_converter_unlocked(unl),
      .sd1_gain(sd1_gain), .sd2_gain(sd2_gain),
      .converter_clock_select(csel), .converter_clock_halve(halve),
      .pll_ratio(pll_ratio), .hw_mode(hw), .deemph_auto_en(dae),
      .sd1_mclk_recovered(smr), .tx_user_data_sel(txu),
      .err_receiver_sel(erx), .vaudio_audio_sel(vau),
      .rx_input_sel(rxs), .tx_input_sel(txs));
   rclmc_dac_model dac (.clk(clk), .interp(ip), .unlocked(unl),
      .gain(sd1_gain), .fsi_tick(fsi_tick), .fso_tick(fso_tick), .bad(bad));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // crystal kept alive only while xrun is set
   always @(posedge clk) begin
      if (xrun) crystal_in <= ~crystal_in;
   end
   task automatic complete_run;
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // one apb transfer; released request needs an edge before the next
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      q = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 50) n_errors++;
   endtask
   task automatic do_rst(input logic c);
      @(posedge clk);
      sys_rst <= 1'b1;
      st <= {c, 6'($random(seed))};
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   task automatic wait_lock(input int lim);
      n = 0;
      while (unl !== 1'b0 && n < lim) begin
         @(posedge clk);
         n++;
      end
      `CHK("lock", 1'b1, n < lim)
   endtask
   function automatic logic [9:0] pll_exp(input logic [7:0] r,
                                          input logic [9:0] p);
      if (r <= 8'h31) return 10'h200;
      if (r >= 8'h3c && r <= 8'h62) return 10'h100;
      if (r >= 8'h78) return 10'h080;
      return p;
   endfunction
   initial begin
      repeat (90000) @(posedge clk);
      n_errors++;
      complete_run();
   end
   initial begin
      seed = 60248;
      {sys_rst, psel, penable, pwrite, fsi_change, fso_change} = 6'h20;
      {core_settled, crystal_in, rx_sel_pin, tx_sel_pin} = 4'h0;
      {paddr, pwdata, st} = '0;
      rate = 8'h30;
      xrun = 1'b1;
      ip = 1'b1;
      do_rst(1'b0);
      `CHK("hw", 1'b0, hw)
      `CHK("pin", 1'b0, unl)
      apb(1'b0, rclmc_pkg::ADDR_CLK, 32'h0);
      `CHK("clkreg", 32'h0, q)
      apb(1'b0, rclmc_pkg::ADDR_STAT, 32'h0);
      `CHK("stat", 2'h1, q[1:0])
      for (i = 0; i < 8; i++) begin
         sel = 2'(i % 4);
         apb(1'b1, rclmc_pkg::ADDR_CLK, {29'h0, 1'($random(seed)), sel});
         apb(1'b0, rclmc_pkg::ADDR_CLK, 32'h0);
         repeat (2) @(posedge clk);
         `CHK("sel", (sel == 2'h3) ? 2'h2 : sel, csel)
         `CHK("halve", (sel == 2'h0) & q[2], halve)
         `CHK("resp", 1'b0, er)
      end
      apb(1'b0, 12'hffc, 32'h0);
      `CHK("unmap", 33'h100000000, {er, q})
      apb(1'b1, rclmc_pkg::ADDR_CLK, 32'h4);
      xrun <= 1'b0;
      repeat (1100) @(posedge clk);
      `CHK("static", 2'h2, csel)
      `CHK("halve off", 1'b0, halve)
      `CHK("sd2 full", rclmc_pkg::RAMP_FULL, sd2_gain)
      pe = pll_ratio;
      for (i = 0; i < 14; i++) begin
         rate <= (i < 7) ? 8'h30 + 8'(i * 12) : 8'($random(seed));
         @(posedge clk);
         pe = pll_exp(rate, pe);
         repeat (3) @(posedge clk);
         `CHK("pll", pe, pll_ratio)
      end
      {rx_sel_pin, tx_sel_pin} <= 2'h3;
      repeat (3) @(posedge clk);
      `CHK("sw sel", 2'h0, {rxs, txs})
      core_settled <= 1'b1;
      repeat (LK) @(posedge clk);
      apb(1'b0, rclmc_pkg::ADDR_STAT, 32'h0);
      `CHK("stat lock", 1'b0, q[0])
      // second output switched onto the converter path
      apb(1'b1, rclmc_pkg::ADDR_CLK, 32'h8);
      repeat (2) @(posedge clk);
      `CHK("sd2 src", 1'b1, sd2_gain == sd1_gain && sd2_gain != 16'h0)
      core_settled <= 1'b0;
      do_rst(1'b1);
      st0 = st;
      `CHK("hw", 1'b1, hw)
      `CHK("strap", {~st0[5], st0[4], st0[2], st0[1], st0[0]},
           {dae, smr, txu, erx, vau})
      `CHK("hw sel", st0[3] ? 2'h1 : 2'h2, csel)
      `CHK("sense", 33'h100000000, {unl, sd1_gain, sd2_gain})
      st <= ~st0;
      repeat (SN + LK + 20) @(posedge clk);
      `CHK("restrap", {st0[5:4], 1'b1, st0[2:0]},
           {~dae, smr, hw, txu, erx, vau})
      `CHK("settle", 1'b1, unl)
      core_settled <= 1'b1;
      wait_lock(20);
      rx_sel_pin <= 1'b1;
      tx_sel_pin <= 1'b0;
      repeat (3) @(posedge clk);
      `CHK("rxtx", 2'h2, {rxs, txs})
      n = 0;
      while (sd1_gain !== rclmc_pkg::RAMP_FULL && n < 60000) begin
         @(posedge clk);
         n++;
      end
      `CHK("ramp", 1'b1, n >= 54960 && n <= 54990)
      ip <= 1'b0;
      fso_change <= 1'b1;
      @(posedge clk);
      fso_change <= 1'b0;
      @(posedge clk);
      `CHK("relock", 1'b1, unl)
      repeat (2) @(posedge clk);
      `CHK("hardmute", 16'h0, sd1_gain)
      // a change in mid-window must restart the full window
      repeat (20) @(posedge clk);
      fsi_change <= 1'b1;
      @(posedge clk);
      fsi_change <= 1'b0;
      wait_lock(LK + 40);
      `CHK("restart", 1'b1, n >= LK && n <= LK + 4)
      repeat (40) @(posedge clk);
      `CHK("decim", 1'b1, sd1_gain >= 16'h0010 && sd1_gain <= 16'h0018)
      `CHK("dac", 1'b0, bad)
      complete_run();
   end
endmodule
`default_nettype wire
